// ### rtl/slk_pkg.sv
/*
 * Package for the sector lock command block: opcodes, frame geometry,
 * lock byte values, reset values and self-timed cycle constants.
 * Assumes a 100 MHz system clock.
 */
package slk_pkg;

    // Opcodes as seen on the serial lines
    localparam logic [7:0] OP_WRITE_ENABLE_COMMAND = 8'h06;
    localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7e;
    localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
    localparam logic [7:0] OP_SET_NL = 8'he3;
    localparam logic [7:0] OP_CLR_ALL_NL = 8'he4;
    localparam logic [7:0] OP_WR_VL = 8'he1;
    localparam logic [7:0] OP_RD_NL = 8'he2;
    localparam logic [7:0] OP_RD_VL = 8'he0;

    // Frame geometry in bits
    localparam int OP_BITS = 8;
    localparam int ADDR_BITS = 32;
    localparam int DATA_BITS = 8;
    localparam int FRAME_W = OP_BITS + ADDR_BITS + DATA_BITS;
    localparam logic [7:0] LEN_OP = 8'h08;
    localparam logic [7:0] LEN_OP_ADDR = 8'h28;
    localparam logic [7:0] LEN_OP_ADDR_DATA = 8'h30;
    localparam int CNT_W = 6;

    // Clock counts at which the last address bit is sampled
    localparam logic [CNT_W-1:0] RD_END_SINGLE = 6'h28;
    localparam logic [CNT_W-1:0] RD_END_QUAD = 6'h0a;

    // Lock byte values
    localparam logic [7:0] LOCK_OFF = 8'h00;
    localparam logic [7:0] LOCK_ON = 8'hff;

    // Values after reset
    localparam logic WEL_RST = 1'b0;
    localparam logic LOCK_BIT_RST = 1'b0;

    // Self-timed cycles; clock period 10 ns
    localparam int CLK_PERIOD_NS = 10;
    localparam int LOCK_SET_TIME_US = 100;
    localparam int LOCK_CLEAR_TIME_US = 200;
    localparam int LOCK_SET_CYC = (LOCK_SET_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int LOCK_CLEAR_CYC =
        (LOCK_CLEAR_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int TIMER_W = 24;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SET,
        ST_CLEAR
    } slk_state_t;

endpackage

// ### rtl/slk_cycle_timer.sv
/*
 * Down-counter that times one self-timed lock cycle.
 * Assumes start is a one-cycle pulse on the system clock and load >= 1.
 */
`timescale 1ns/100ps
module slk_cycle_timer import slk_pkg::*; #(
    parameter int W = TIMER_W
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire logic [W-1:0] load,
    output logic busy,
    output logic done
);

    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;
    logic busy_r;
    logic done_r;
    logic last;

    assign last = busy_r && (count_r == {{(W-1){1'b0}}, 1'b1});
    assign count_nxt = start ? load :
        (busy_r ? count_r - {{(W-1){1'b0}}, 1'b1} : count_r);

    always_ff @(posedge clock) begin
        if (rst) begin
            count_r <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            busy_r <= start || (busy_r && !last);
            done_r <= last && !start;
        end
    end

    assign busy = busy_r;
    assign done = done_r;

endmodule

// ### rtl/slk_lock_cmd.sv
/*
 * Sector lock command logic of a serial flash: global lock/unlock,
 * set and clear-all of nonvolatile lock bits, volatile lock writes and
 * lock byte reads. The frame shifter runs on the host's shift clock; the
 * decode, lock storage and self-timed cycles run on the system clock.
 * Assumes the shift clock stops while chip select is high, and that
 * quad_command_mode changes only between frames.
 */
`timescale 1ns/100ps

// Behaviour
// - Opcode-only global lock frame sets every volatile lock bit.
// - Opcode-only global unlock frame clears every volatile lock bit.
// - Set-nonvolatile-lock carries opcode plus 32 address bits, always.
// - Set lock frame not ending after last address clock is dropped.
// - Valid set runs timed cycle, then clears busy, latch, locks byte.
// - Nonvolatile byte 00H leaves sector open; FFH blocks program/erase.
// - Clear-all must end after clock 8 single or clock 2 quad.
// - Valid clear-all runs timed cycle, then clears all nonvolatile bytes.
// - Nonvolatile bytes set singly, cleared only all together.
// - Volatile write carries opcode, 32-bit address and one data byte.
// - Volatile write data other than 00H or FFH is ignored.
// - Volatile byte FFH protects its sector; 00H unprotects it.
// - Volatile write acts at chip select rise; latch cleared after.
// - Lock byte reads drive data from falling edge after last address.
// - Lock byte reads during erase, program or write are ignored.
// - Write enable latch is set only by the write enable command.
// - Busy flag stays visible to status polling during timed cycles.
// - Lock-changing commands are rejected while program or erase is suspended.
module slk_lock_cmd import slk_pkg::*; #(
    parameter int NUM_SECT = 16,
    parameter int SECT_LSB = 16,
    parameter int SET_CYC = LOCK_SET_CYC,
    parameter int CLEAR_CYC = LOCK_CLEAR_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    input wire logic quad_command_mode,
    input wire logic array_busy,
    input wire logic suspended,
    output logic write_enable_latch,
    output logic write_in_progress,
    output logic [NUM_SECT-1:0] protect
);

    localparam int IW = (NUM_SECT > 1) ? $clog2(NUM_SECT) : 1;

    function automatic logic [IW-1:0] sect_idx(input logic [31:0] a);
        sect_idx = a[SECT_LSB +: IW];
    endfunction

    function automatic logic idx_ok(input logic [31:0] a);
        idx_ok = ({{(32-IW){1'b0}}, sect_idx(a)} < 32'(NUM_SECT));
    endfunction

    // Lock storage, one bit per sector; a set bit reads back as FFH
    logic [NUM_SECT-1:0] nl_r;
    logic [NUM_SECT-1:0] vl_r;

    // Link side: frame shifter on the shift clock
    logic lk_clr;
    logic first_r;
    logic [CNT_W-1:0] cnt_r;
    logic [FRAME_W-1:0] sh_r;
    logic tog_r;
    logic lq1_r;
    logic lq2_r;
    logic lr1_r;
    logic lr2_r;
    logic rd_ok_r;
    logic [7:0] ob_r;
    logic [3:0] io_out_r;
    logic [3:0] io_oe_r;

    // Chip select high or system reset ends any output drive
    assign lk_clr = cs_n | rst;

    always_ff @(posedge sclk or posedge lk_clr) begin
        if (lk_clr) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    // Quad mode and read permission are levels from the system clock
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            lq1_r <= 1'b0;
            lq2_r <= 1'b0;
            lr1_r <= 1'b0;
            lr2_r <= 1'b0;
        end else begin
            lq1_r <= quad_command_mode;
            lq2_r <= lq1_r;
            lr1_r <= rd_ok_r;
            lr2_r <= lr1_r;
        end
    end

    logic [CNT_W-1:0] cnt_nxt;
    logic [FRAME_W-1:0] sh_nxt;

    assign cnt_nxt = first_r ? {{(CNT_W-1){1'b0}}, 1'b1} :
        ((&cnt_r) ? cnt_r : cnt_r + {{(CNT_W-1){1'b0}}, 1'b1});
    // All frame bits are taken on the rising shift clock edge
    assign sh_nxt = lq2_r ? {sh_r[FRAME_W-5:0], io_in} :
        {sh_r[FRAME_W-2:0], io_in[0]};

    // Count and bits stay put after the frame so the system side can read
    // them once chip select is seen high; the toggle marks a real frame.
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            sh_r <= '0;
            tog_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            if (first_r) begin
                tog_r <= ~tog_r;
            end
        end
    end

    // Read path. The lock bits only change after chip select rises and a
    // read is refused while a cycle runs, so they are static while read.
    logic [7:0] rd_op;
    logic [31:0] rd_addr;
    logic rd_is_lock;
    logic rd_bit;
    logic [7:0] rd_byte;
    logic rd_start;
    logic [7:0] ob_nxt;

    assign rd_op = sh_r[OP_BITS+ADDR_BITS-1:ADDR_BITS];
    assign rd_addr = sh_r[ADDR_BITS-1:0];
    assign rd_is_lock = (rd_op == OP_RD_NL) || (rd_op == OP_RD_VL);
    assign rd_bit = idx_ok(rd_addr) && ((rd_op == OP_RD_NL) ?
        nl_r[sect_idx(rd_addr)] : vl_r[sect_idx(rd_addr)]);
    assign rd_byte = rd_bit ? LOCK_ON : LOCK_OFF;
    assign rd_start = rd_is_lock && lr2_r &&
        (cnt_r == (lq2_r ? RD_END_QUAD : RD_END_SINGLE));
    assign ob_nxt = rd_start ? rd_byte :
        (lq2_r ? {ob_r[3:0], ob_r[7:4]} : {ob_r[6:0], ob_r[7]});

    // Data leaves on falling edges, repeating the byte until deselect
    always_ff @(negedge sclk or posedge lk_clr) begin
        if (lk_clr) begin
            ob_r <= '0;
            io_out_r <= '0;
            io_oe_r <= '0;
        end else begin
            ob_r <= ob_nxt;
            io_out_r <= lq2_r ? ob_nxt[7:4] : {2'b00, ob_nxt[7], 1'b0};
            if (rd_start) begin
                io_oe_r <= lq2_r ? 4'hf : 4'h2;
            end
        end
    end

    assign io_out = io_out_r;
    assign io_oe = io_oe_r;

    // System side: chip select and frame toggle cross by two flip-flops
    logic cs1_r;
    logic cs2_r;
    logic cs3_r;
    logic t1_r;
    logic t2_r;
    logic seen_r;
    logic cs_rise;
    logic frame_new;

    always_ff @(posedge clock) begin
        if (rst) begin
            cs1_r <= 1'b1;
            cs2_r <= 1'b1;
            cs3_r <= 1'b1;
            t1_r <= 1'b0;
            t2_r <= 1'b0;
            seen_r <= 1'b0;
        end else begin
            cs1_r <= cs_n;
            cs2_r <= cs1_r;
            cs3_r <= cs2_r;
            t1_r <= tog_r;
            t2_r <= t1_r;
            if (cs_rise) begin
                seen_r <= t2_r;
            end
        end
    end

    assign cs_rise = cs2_r && !cs3_r;
    assign frame_new = cs_rise && (t2_r != seen_r);

    // Frame decode by its exact length in bits
    logic [7:0] nbits;
    logic len_op;
    logic len_addr;
    logic len_data;
    logic [7:0] op_a;
    logic [7:0] op_b;
    logic [7:0] op_c;
    logic [31:0] addr_b;
    logic [31:0] addr_c;
    logic [7:0] data_c;
    logic data_ok;

    assign nbits = quad_command_mode ? {cnt_r, 2'b00} : {2'b00, cnt_r};
    assign len_op = frame_new && (nbits == LEN_OP);
    assign len_addr = frame_new && (nbits == LEN_OP_ADDR);
    assign len_data = frame_new && (nbits == LEN_OP_ADDR_DATA);
    assign op_a = sh_r[OP_BITS-1:0];
    assign op_b = sh_r[OP_BITS+ADDR_BITS-1:ADDR_BITS];
    assign addr_b = sh_r[ADDR_BITS-1:0];
    assign op_c = sh_r[FRAME_W-1:ADDR_BITS+DATA_BITS];
    assign addr_c = sh_r[ADDR_BITS+DATA_BITS-1:DATA_BITS];
    assign data_c = sh_r[DATA_BITS-1:0];
    assign data_ok = (data_c == LOCK_ON) || (data_c == LOCK_OFF);

    slk_state_t state_r;
    slk_state_t state_nxt;
    logic wel_r;
    logic wip_r;
    logic [IW-1:0] set_idx_r;
    logic [NUM_SECT-1:0] protect_r;
    logic idle;
    logic may_write;
    logic cmd_write_enable_command;
    logic cmd_glock;
    logic cmd_gunlock;
    logic cmd_set;
    logic cmd_clear;
    logic cmd_vl;
    logic tmr_busy;
    logic tmr_done;

    assign idle = (state_r == ST_IDLE) && !array_busy;
    // Set, clear-all and volatile writes need an idle array, no suspend and a set latch
    assign may_write = idle && !suspended && wel_r;

    assign cmd_write_enable_command = len_op && (op_a == OP_WRITE_ENABLE_COMMAND) && idle;
    assign cmd_glock = len_op && (op_a == OP_GLOBAL_LOCK) &&
        idle && !suspended;
    assign cmd_gunlock = len_op && (op_a == OP_GLOBAL_UNLOCK) &&
        idle && !suspended;
    assign cmd_clear = len_op && (op_a == OP_CLR_ALL_NL) &&
        may_write;
    assign cmd_set = len_addr && (op_b == OP_SET_NL) &&
        may_write;
    assign cmd_vl = len_data && (op_c == OP_WR_VL) && data_ok &&
        may_write;

    slk_cycle_timer #(
        .W(TIMER_W)
    ) i_slk_cycle_timer (
        .clock(clock),
        .rst(rst),
        .start(cmd_set || cmd_clear),
        .load(cmd_set ? TIMER_W'(SET_CYC) : TIMER_W'(CLEAR_CYC)),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (cmd_set) begin
                    state_nxt = ST_SET;
                end else if (cmd_clear) begin
                    state_nxt = ST_CLEAR;
                end
            end
            ST_SET, ST_CLEAR: begin
                if (tmr_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= ST_IDLE;
            set_idx_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (cmd_set) begin
                set_idx_r <= sect_idx(addr_b);
            end
        end
    end

    // Busy follows the state so status polling sees it throughout
    always_ff @(posedge clock) begin
        if (rst) begin
            wip_r <= 1'b0;
            rd_ok_r <= 1'b0;
        end else begin
            wip_r <= (state_nxt != ST_IDLE);
            rd_ok_r <= (state_nxt == ST_IDLE) && !array_busy && !tmr_busy;
        end
    end

    // Latch: set only by write enable, dropped when a lock write ends
    always_ff @(posedge clock) begin
        if (rst) begin
            wel_r <= WEL_RST;
        end else if (cmd_write_enable_command) begin
            wel_r <= 1'b1;
        end else if (cmd_vl || tmr_done) begin
            wel_r <= 1'b0;
        end
    end

    // Nonvolatile bits: set one at a time, cleared only as a group
    always_ff @(posedge clock) begin
        if (rst) begin
            nl_r <= {NUM_SECT{LOCK_BIT_RST}};
        end else if (tmr_done && state_r == ST_CLEAR) begin
            nl_r <= '0;
        end else if (tmr_done && state_r == ST_SET &&
                {{(32-IW){1'b0}}, set_idx_r} < 32'(NUM_SECT)) begin
            nl_r[set_idx_r] <= 1'b1;
        end
    end

    // Volatile bits change at once, with no timed wait
    always_ff @(posedge clock) begin
        if (rst) begin
            vl_r <= {NUM_SECT{LOCK_BIT_RST}};
        end else if (cmd_glock) begin
            vl_r <= '1;
        end else if (cmd_gunlock) begin
            vl_r <= '0;
        end else if (cmd_vl && idx_ok(addr_c)) begin
            vl_r[sect_idx(addr_c)] <= (data_c == LOCK_ON);
        end
    end

    // A sector is guarded when either of its lock bytes reads FFH
    always_ff @(posedge clock) begin
        if (rst) begin
            protect_r <= '0;
        end else begin
            protect_r <= nl_r | vl_r;
        end
    end

    assign write_enable_latch = wel_r;
    assign write_in_progress = wip_r;
    assign protect = protect_r;

endmodule

// ### verification/slk_lock_monitor.sv
/* Checker for slk_lock_cmd ports, bound below.
   Assumes sclk stops between frames. */
`timescale 1ns/100ps
module slk_lock_monitor import slk_pkg::*; #(
    parameter int NUM_SECT = 16,
    parameter int SET_CYC = LOCK_SET_CYC,
    parameter int CLEAR_CYC = LOCK_CLEAR_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] io_oe,
    input wire logic quad_command_mode,
    input wire logic array_busy,
    input wire logic suspended,
    input wire logic write_enable_latch,
    input wire logic write_in_progress,
    input wire logic [NUM_SECT-1:0] protect
);
    logic [31:0] wip_cnt_r;
    always_ff @(posedge clock) begin
        if (rst || !write_in_progress) begin
            wip_cnt_r <= 32'h0;
        end else begin
            wip_cnt_r <= wip_cnt_r + 32'h1;
        end
    end
    sequence s_cycle_start;
        $rose(write_in_progress);
    endsequence
    sequence s_cycle_end;
        $fell(write_in_progress);
    endsequence
    AST_END_DROPS_LATCH: assert property (
        @(posedge clock) disable iff (rst)
        s_cycle_end |-> !write_enable_latch) else $error("latch kept");
    AST_START_NEEDS_LATCH: assert property (
        @(posedge clock) disable iff (rst) s_cycle_start |->
        write_enable_latch && !suspended && !array_busy)
        else $error("cycle without latch");
    AST_CYCLE_MIN: assert property (
        @(posedge clock) disable iff (rst)
        s_cycle_end |-> wip_cnt_r >= SET_CYC) else $error("cycle short");
    AST_CYCLE_MAX: assert property (
        @(posedge clock) disable iff (rst)
        write_in_progress |-> wip_cnt_r <= CLEAR_CYC + 2)
        else $error("cycle long");
    AST_HOLD_IN_CYCLE: assert property (
        @(posedge clock) disable iff (rst)
        write_in_progress && $past(write_in_progress) |-> $stable(protect))
        else $error("locks moved in cycle");
    AST_SUSPEND_FREEZE: assert property (
        @(posedge clock) disable iff (rst)
        (suspended && !write_in_progress)[*8] |-> $stable(protect))
        else $error("locks moved while suspended");
    AST_CS_HIGH_QUIET: assert property (
        @(posedge clock) disable iff (rst)
        cs_n |-> io_oe == 4'h0) else $error("drive while deselected");
    AST_OE_SHAPE: assert property (
        @(posedge sclk) disable iff (rst)
        io_oe != 4'h0 |-> io_oe == (quad_command_mode ? 4'hf : 4'h2))
        else $error("wrong drive lines");
    AST_BUSY_NO_READ: assert property (
        @(posedge sclk) disable iff (rst)
        (array_busy || write_in_progress)[*8] |-> io_oe == 4'h0)
        else $error("read while busy");
endmodule

bind slk_lock_cmd slk_lock_monitor #(.NUM_SECT(NUM_SECT),
    .SET_CYC(SET_CYC), .CLEAR_CYC(CLEAR_CYC)) i_slk_lock_monitor (
    .clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n), .io_oe(io_oe),
    .quad_command_mode(quad_command_mode), .array_busy(array_busy),
    .suspended(suspended), .write_enable_latch(write_enable_latch),
    .write_in_progress(write_in_progress), .protect(protect));

// ### verification/slk_host_model.sv
/* Host flash controller model that sends frames and collects read data.
   Assumes quad stays stable while a frame runs. */
`timescale 1ns/100ps
module slk_host_model (
    output logic sclk,
    output logic cs_n,
    output logic [3:0] io_in,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe,
    input wire logic quad
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        io_in = 4'h0;
    end
    // Clock only inside frames; idle lines flip so stale data is not read
    task automatic xfer(input logic [47:0] v, input int nb,
        input logic rd_en, output logic [7:0] rd, output logic [3:0] oe);
        int w;
        begin
            w = quad ? 4 : 1;
            rd = 8'h00;
            oe = 4'h0;
            cs_n = 1'b0;
            for (int k = 0; k < nb / w; k++) begin
                io_in = quad ? v[47:44] : {~io_in[3:1], v[47]};
                v = v << w;
                #32 sclk = 1'b1;
                #32 sclk = 1'b0;
            end
            if (rd_en) begin
                repeat (8 / w) begin
                    io_in = ~io_in;
                    #32 sclk = 1'b1;
                    rd = quad ? {rd[3:0], io_out} : {rd[6:0], io_out[1]};
                    oe = io_oe;
                    #32 sclk = 1'b0;
                end
            end
            #32 cs_n = 1'b1;
            io_in = ~io_in;
            #64;
        end
    endtask
endmodule

// ### verification/test_sector_lock_register_commands.sv
/* Self-checking bench for slk_lock_cmd driven by the host model.
   Assumes shortened self-timed cycles set through parameters. */
`timescale 1ns/100ps
module test_sector_lock_register_commands import slk_pkg::*; ();
    logic clock, rst, sclk, cs_n, quad_command_mode, array_busy, suspended;
    logic [3:0] io_in, io_out, io_oe;
    logic write_enable_latch, write_in_progress;
    logic [15:0] protect;
    int error_cnt, n_compared;
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Long enough that a full read frame fits inside one set cycle
    slk_lock_cmd #(.NUM_SECT(16), .SECT_LSB(16), .SET_CYC(600),
        .CLEAR_CYC(800)) i_slk_lock_cmd (.clock(clock), .rst(rst),
        .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
        .io_oe(io_oe), .quad_command_mode(quad_command_mode),
        .array_busy(array_busy), .suspended(suspended),
        .write_enable_latch(write_enable_latch),
        .write_in_progress(write_in_progress), .protect(protect));
    slk_host_model i_slk_host_model (.sclk(sclk), .cs_n(cs_n),
        .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
        .quad(quad_command_mode));
    task automatic summarize();
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk_flag(input logic g, input logic e, input string m);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic chk_val(input logic [15:0] g, input logic [15:0] e,
        input string m);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    function automatic logic [47:0] fr(input logic [7:0] op,
        input logic [3:0] sec, input logic [7:0] d);
        return {op, 12'h000, sec, 16'h0000, d};
    endfunction
    task automatic run(input logic [47:0] v, input int nb);
        logic [7:0] d;
        logic [3:0] o;
        @(posedge clock);
        #3;
        i_slk_host_model.xfer(v, nb, 1'b0, d, o);
        repeat (8) @(posedge clock);
        #1;
    endtask
    task automatic rd(input logic [7:0] op, input logic [3:0] sec,
        input logic [7:0] e, input logic [3:0] oe_e);
        logic [7:0] d;
        logic [3:0] o;
        @(posedge clock);
        #3;
        i_slk_host_model.xfer(fr(op, sec, 8'h00), 40, 1'b1, d, o);
        chk_val({12'h000, o}, {12'h000, oe_e}, "read drive lines");
        if (oe_e != 4'h0) begin
            chk_val({8'h00, d}, {8'h00, e}, "read byte");
        end
    endtask
    task automatic wait_idle();
        int i;
        i = 0;
        while (write_in_progress !== 1'b0 && i < 1000) begin
            @(posedge clock);
            #1;
            i++;
        end
        if (i >= 1000) begin
            error_cnt++;
            $display("MISMATCH %0t cycle never ended", $time);
            summarize();
        end
        @(posedge clock);
        #1;
    endtask
    task automatic t_global();
        chk_val(protect, 16'h0000, "locks after reset");
        chk_flag(write_enable_latch, 1'b0, "latch after reset");
        run(fr(OP_GLOBAL_LOCK, 4'h0, 8'h00), 8);
        chk_val(protect, 16'hffff, "global lock");
        rd(OP_RD_VL, 4'h3, 8'hff, 4'h2);
        run(fr(OP_GLOBAL_UNLOCK, 4'h0, 8'h00), 8);
        chk_val(protect, 16'h0000, "global unlock");
        rd(OP_RD_VL, 4'h3, 8'h00, 4'h2);
    endtask
    task automatic t_set();
        run(fr(OP_SET_NL, 4'h5, 8'h00), 40);
        chk_val(protect, 16'h0000, "set without latch");
        run(fr(OP_WRITE_ENABLE_COMMAND, 4'h0, 8'h00), 8);
        chk_flag(write_enable_latch, 1'b1, "latch set");
        run(fr(OP_SET_NL, 4'h5, 8'h00), 39);
        chk_flag(write_in_progress, 1'b0, "short set frame");
        run(fr(OP_SET_NL, 4'h5, 8'h00), 40);
        chk_flag(write_in_progress, 1'b1, "set cycle");
        rd(OP_RD_NL, 4'h5, 8'h00, 4'h0);
        chk_flag(write_in_progress, 1'b1, "busy polled");
        wait_idle();
        chk_flag(write_enable_latch, 1'b0, "latch after set");
        chk_val(protect, 16'h0020, "one sector set");
        rd(OP_RD_NL, 4'h5, 8'hff, 4'h2);
        rd(OP_RD_NL, 4'h4, 8'h00, 4'h2);
    endtask
    task automatic t_vol();
        run(fr(OP_WRITE_ENABLE_COMMAND, 4'h0, 8'h00), 8);
        run(fr(OP_WR_VL, 4'h2, 8'h5a), 48);
        chk_val(protect, 16'h0020, "bad volatile data");
        run(fr(OP_WR_VL, 4'h2, 8'hff), 48);
        chk_flag(write_in_progress, 1'b0, "no timed wait");
        chk_flag(write_enable_latch, 1'b0, "latch after write");
        chk_val(protect, 16'h0024, "volatile lock");
        run(fr(OP_WRITE_ENABLE_COMMAND, 4'h0, 8'h00), 8);
        run(fr(OP_WR_VL, 4'h5, 8'h00), 48);
        chk_val(protect, 16'h0024, "nonvolatile bit kept");
        rd(OP_RD_VL, 4'h5, 8'h00, 4'h2);
        run(fr(OP_WRITE_ENABLE_COMMAND, 4'h0, 8'h00), 8);
        run(fr(OP_CLR_ALL_NL, 4'h0, 8'h00), 9);
        chk_flag(write_in_progress, 1'b0, "long clear frame");
        run(fr(OP_CLR_ALL_NL, 4'h0, 8'h00), 8);
        chk_flag(write_in_progress, 1'b1, "clear cycle");
        wait_idle();
        chk_flag(write_enable_latch, 1'b0, "latch after clear");
        chk_val(protect, 16'h0004, "clear all");
    endtask
    task automatic t_quad();
        @(posedge clock);
        quad_command_mode <= 1'b1;
        run(48'h0, 8);
        run(fr(OP_WRITE_ENABLE_COMMAND, 4'h0, 8'h00), 8);
        run(fr(OP_SET_NL, 4'h7, 8'h00), 40);
        wait_idle();
        rd(OP_RD_NL, 4'h7, 8'hff, 4'hf);
        run(fr(OP_WRITE_ENABLE_COMMAND, 4'h0, 8'h00), 8);
        run(fr(OP_CLR_ALL_NL, 4'h0, 8'h00), 12);
        chk_flag(write_in_progress, 1'b0, "long quad clear");
        run(fr(OP_CLR_ALL_NL, 4'h0, 8'h00), 8);
        wait_idle();
        chk_val(protect, 16'h0004, "quad clear");
        @(posedge clock);
        quad_command_mode <= 1'b0;
        run(48'h0, 8);
    endtask
    task automatic t_block();
        @(posedge clock);
        suspended <= 1'b1;
        run(fr(OP_GLOBAL_LOCK, 4'h0, 8'h00), 8);
        run(fr(OP_WRITE_ENABLE_COMMAND, 4'h0, 8'h00), 8);
        run(fr(OP_WR_VL, 4'h9, 8'hff), 48);
        chk_val(protect, 16'h0004, "lock while suspended");
        @(posedge clock);
        suspended <= 1'b0;
        array_busy <= 1'b1;
        rd(OP_RD_VL, 4'h2, 8'hff, 4'h0);
        @(posedge clock);
        array_busy <= 1'b0;
        rd(OP_RD_VL, 4'h2, 8'hff, 4'h2);
    endtask
    initial begin
        rst = 1'b1;
        quad_command_mode = 1'b0;
        array_busy = 1'b0;
        suspended = 1'b0;
        error_cnt = 0;
        n_compared = 0;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
        t_global();
        t_set();
        t_vol();
        t_quad();
        t_block();
        summarize();
    end
    initial begin
        #1000000;
        error_cnt++;
        $display("MISMATCH %0t run too long", $time);
        summarize();
    end
endmodule
